//--- hw/autoreset_timer.sv
// Millisecond timeout that forces a signal to Not Available when frames stop.
`timescale 1ns/1ps
`default_nettype none
module autoreset_timer
  import can_sig_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              enable,
  input  wire logic              restart,
  input  wire logic              ms_tick,
  input  wire logic [ARST_W-1:0] limit_ms,
  output logic                   expire
);

  logic [ARST_W-1:0] cnt_q;
  logic [ARST_W-1:0] cnt_d;
  logic              armed_q;
  logic              armed_d;
  wire  logic        hit;

  // A zero limit disables the timeout.
  assign hit = armed_q && ms_tick && (limit_ms != '0) && (cnt_q + 1'b1 >= limit_ms);
  assign expire = hit;
  assign cnt_d = restart ? '0 : (armed_q && ms_tick) ? cnt_q + 1'b1 : cnt_q;
  assign armed_d = enable && (restart || (armed_q && !hit));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q   <= '0;
      armed_q <= 1'b0;
    end else begin
      cnt_q   <= cnt_d;
      armed_q <= armed_d;
    end
  end

endmodule
`default_nettype wire

//--- hw/can_input_extractor.sv
// Two CAN input signal extractors with an APB register file and interrupt.
//
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module can_input_extractor
  import can_sig_pkg::*;
#(
  parameter int CYCLES_PER_MS = TICK_CYCLES
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic [7:0]           paddr,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [31:0]          pwdata,
  input  wire logic [3:0]           pstrb,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 rx_valid,
  input  wire frame_t               rx_frame,
  input  wire logic                 lb_valid,
  input  wire frame_t               lb_frame,
  output logic                      lb_ready,
  output sig_t [NUM_EXT-1:0]        sig_out,
  output logic [NUM_EXT-1:0]        sig_upd,
  output logic                      irq
);

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  function automatic logic [31:0] reg_mask(input logic [2:0] idx);
    unique case (idx)
      3'h0:    reg_mask = CTRL_MASK;
      3'h1:    reg_mask = PGN_MASK;
      3'h2:    reg_mask = SA_MASK;
      3'h7:    reg_mask = ARST_MASK;
      default: reg_mask = 32'hFFFF_FFFF;
    endcase
  endfunction

  function automatic logic [31:0] reg_rst(input logic [2:0] idx);
    unique case (idx)
      3'h0: reg_rst = CTRL_RST;
      3'h1: reg_rst = PGN_RST;
      3'h2: reg_rst = SA_RST;
      3'h3: reg_rst = RES_RST;
      3'h4: reg_rst = OFFS_RST;
      3'h5: reg_rst = MAX_RST;
      3'h6: reg_rst = MIN_RST;
      3'h7: reg_rst = ARST_RST;
    endcase
  endfunction

  function automatic logic [31:0] strb_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    for (int b = 0; b < 4; b++) begin
      strb_merge[8*b +: 8] = strb[b] ? new_v[8*b +: 8] : old_v[8*b +: 8];
    end
  endfunction

  function automatic logic [2:0] pos_idx(input logic [3:0] p);
    if (p == 4'h0) begin
      pos_idx = 3'h0;
    end else if (p > 4'h8) begin
      pos_idx = 3'h7;
    end else begin
      pos_idx = 3'(p - 4'h1);
    end
  endfunction

  function automatic logic [31:0] get_raw(input sig_type_t t,
                                          input logic [63:0] sh,
                                          input logic [7:0]  d);
    unique case (t)
      SIG_D1:  get_raw = {31'h0, d[0]};
      SIG_D2:  get_raw = {30'h0, d[1:0]};
      SIG_D4:  get_raw = {28'h0, d[3:0]};
      SIG_C1:  get_raw = {24'h0, sh[7:0]};
      SIG_C2:  get_raw = {16'h0, sh[15:0]};
      SIG_C4:  get_raw = sh[31:0];
      default: get_raw = 32'h0;
    endcase
  endfunction

  function automatic sig_t classify(input sig_type_t t, input logic [31:0] r);
    logic [7:0]  tb;
    logic [31:0] low;
    logic [4:0]  sh;
    logic        cont;
    classify = '{state: ST_VALID, code: 26'h0, value: 17'h0};
    tb   = 8'h0;
    low  = 32'h0;
    sh   = 5'h0;
    cont = 1'b0;
    unique case (t)
      SIG_D2: begin
        if (r[1:0] == 2'h2) begin
          classify.state = ST_ERROR;
        end else if (r[1:0] == 2'h3) begin
          classify.state = ST_NA;
        end
      end
      SIG_D4: begin
        if (r[3:0] == 4'hF) begin
          classify.state = ST_NA;
        end else if (r[3:0] == 4'hE) begin
          classify.state = ST_ERROR;
        end else if (r[3:0] >= 4'h2) begin
          classify.state = ST_SPECIAL;
          classify.code  = 26'(r[3:0] - 4'h2);
        end
      end
      SIG_C1: begin
        cont = 1'b1;
        tb   = r[7:0];
      end
      SIG_C2: begin
        cont = 1'b1;
        tb   = r[15:8];
        low  = {24'h0, r[7:0]};
        sh   = 5'd8;
      end
      SIG_C4: begin
        cont = 1'b1;
        tb   = r[31:24];
        low  = {8'h0, r[23:0]};
        sh   = 5'd24;
      end
      default: classify.state = (t == SIG_D1) ? ST_VALID : ST_NA;
    endcase
    if (cont) begin
      if (tb == NA_TOP) begin
        classify.state = ST_NA;
      end else if (tb == ERROR_TOP) begin
        classify.state = ST_ERROR;
        classify.code  = 26'(low);
      end else if (tb >= SPECIAL_TOP) begin
        classify.state = ST_SPECIAL;
        classify.code  = 26'(({24'h0, 8'(tb - SPECIAL_TOP)} << sh) | low);
      end
    end
  endfunction

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  logic [31:0]        cfg_q [NUM_EXT][8];
  logic [INT_W-1:0]   int_stat_q;
  logic [INT_W-1:0]   int_mask_q;
  logic [31:0]        prdata_q;
  logic               pslverr_q;
  sig_t               sig_q [NUM_EXT];
  wire  logic         setup;
  wire  logic         wr_acc;
  wire  logic         cfg_hit;
  wire  logic         out_hit;
  wire  logic         stat_hit;
  wire  logic         mask_hit;
  wire  logic         mapped;
  wire  logic         bad;
  wire  logic         cfg_inst;
  wire  logic [2:0]   cfg_idx;
  wire  logic         out_inst;
  wire  logic [31:0]  rd_data;
  wire  logic [INT_W-1:0] events;
  wire  logic [INT_W-1:0] int_clr;

  assign setup    = psel && !penable;
  assign wr_acc   = psel && penable && pwrite && !pslverr_q;
  assign cfg_hit  = (paddr < OFS_VAL0);
  assign out_hit  = (paddr >= OFS_VAL0) && (paddr <= OFS_STATE1);
  assign stat_hit = (paddr == OFS_INT_STAT);
  assign mask_hit = (paddr == OFS_INT_MASK);
  assign mapped   = (paddr[1:0] == 2'h0) && (cfg_hit || out_hit || stat_hit || mask_hit);
  assign bad      = !mapped || (pwrite && out_hit);
  assign cfg_inst = (paddr >= INST_STRIDE);
  assign cfg_idx  = paddr[4:2];
  assign out_inst = (paddr >= OFS_VAL1);

  assign rd_data = cfg_hit  ? cfg_q[cfg_inst][cfg_idx] :
                   out_hit  ? (paddr[2] ?
                              {2'h0, sig_q[out_inst].code, 2'h0, sig_q[out_inst].state} :
                              {15'h0, sig_q[out_inst].value}) :
                   stat_hit ? {28'h0, int_stat_q} :
                   mask_hit ? {28'h0, int_mask_q} :
                   32'h0;

  assign prdata  = prdata_q;
  assign pready  = 1'b1;
  assign pslverr = pslverr_q && psel && penable;

  // Read data and the error answer are captured in the setup phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= 32'h0;
      pslverr_q <= 1'b0;
    end else if (setup) begin
      prdata_q  <= (bad || pwrite) ? 32'h0 : rd_data;
      pslverr_q <= bad;
    end
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_EXT; i++) begin
        for (int j = 0; j < 8; j++) begin
          cfg_q[i][j] <= reg_rst(3'(j));
        end
      end
      int_mask_q <= '0;
    end else if (wr_acc) begin
      if (cfg_hit) begin
        cfg_q[cfg_inst][cfg_idx] <= strb_merge(cfg_q[cfg_inst][cfg_idx], pwdata, pstrb)
                                    & reg_mask(cfg_idx);
      end
      if (mask_hit && pstrb[0]) begin
        int_mask_q <= pwdata[INT_W-1:0];
      end
    end
  end

  // ----------------------------------------
  // Interrupt status
  // ----------------------------------------
  assign int_clr = (wr_acc && stat_hit && pstrb[0]) ? pwdata[INT_W-1:0] : '0;
  assign irq     = |(int_stat_q & int_mask_q);

  // A new event wins over a clear in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_stat_q <= '0;
    end else begin
      int_stat_q <= (int_stat_q & ~int_clr) | events;
    end
  end

  // ----------------------------------------
  // Frame source and millisecond tick
  // ----------------------------------------
  frame_t       pend_q;
  logic         pend_v_q;
  logic [31:0]  tick_cnt_q;
  wire  logic   ms_tick;
  wire  logic   f_valid;
  wire  frame_t f_frame;

  // Received frames go first; a colliding own frame is held until a cycle with no received frame.
  assign lb_ready = !pend_v_q;
  assign f_valid  = rx_valid || pend_v_q || lb_valid;
  assign f_frame  = rx_valid ? rx_frame : pend_v_q ? pend_q : lb_frame;
  assign ms_tick  = (tick_cnt_q == 32'(CYCLES_PER_MS - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q     <= '0;
      pend_v_q   <= 1'b0;
      tick_cnt_q <= 32'h0;
    end else begin
      tick_cnt_q <= ms_tick ? 32'h0 : tick_cnt_q + 32'h1;
      if (rx_valid && lb_valid && !pend_v_q) begin
        pend_q   <= lb_frame;
        pend_v_q <= 1'b1;
      end else if (!rx_valid) begin
        pend_v_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Extractor instances
  // ----------------------------------------
  for (genvar g = 0; g < NUM_EXT; g++) begin : g_ext
    wire  sig_type_t          s_type;
    wire  logic               s_filt;
    wire  logic [2:0]         byte_i;
    wire  logic [2:0]         bit_i;
    wire  logic [63:0]        shifted;
    wire  logic [7:0]         dfield;
    wire  logic [31:0]        raw;
    wire  logic               is_cont;
    wire  logic               accept;
    wire  logic               expire;
    wire  sig_t               cls;
    wire  logic signed [64:0] prod;
    wire  logic signed [64:0] scaled;
    wire  logic signed [64:0] lo;
    wire  logic signed [64:0] hi;
    wire  logic signed [64:0] clamp;
    wire  logic signed [64:0] span;
    wire  logic signed [64:0] diff;
    wire  logic [48:0]        quot;
    wire  logic [16:0]        norm;
    wire  logic [16:0]        value;
    wire  sig_t               sig_d;

    assign s_type  = sig_type_t'(cfg_q[g][0][CTRL_TYPE_LSB +: 3]);
    assign s_filt  = cfg_q[g][0][CTRL_FILT_BIT];
    assign byte_i  = pos_idx(cfg_q[g][0][CTRL_BYTE_LSB +: 4]);
    assign bit_i   = pos_idx(cfg_q[g][0][CTRL_BIT_LSB +: 4]);
    assign shifted = f_frame.data >> {byte_i, 3'h0};
    assign dfield  = shifted[7:0] >> bit_i;
    assign raw     = get_raw(s_type, shifted, dfield);
    assign is_cont = (s_type == SIG_C1) || (s_type == SIG_C2) || (s_type == SIG_C4);

    assign accept = f_valid && f_frame.single && (s_type != SIG_UNDEF)
                    && (f_frame.pgn == cfg_q[g][1][17:0])
                    && (!s_filt || (f_frame.sa == cfg_q[g][2][7:0]));

    assign cls    = classify(s_type, raw);
    assign prod   = $signed({1'b0, raw}) * $signed(cfg_q[g][3]);
    assign scaled = prod + {{33{cfg_q[g][4][31]}}, cfg_q[g][4]};
    assign lo     = {{33{cfg_q[g][6][31]}}, cfg_q[g][6]};
    assign hi     = {{33{cfg_q[g][5][31]}}, cfg_q[g][5]};
    assign clamp  = (scaled < lo) ? lo : (scaled > hi) ? hi : scaled;
    assign span   = hi - lo;
    assign diff   = clamp - lo;
    assign quot   = (span > 0) ? {diff[32:0], 16'h0} / {16'h0, span[32:0]} : 49'h0;
    assign norm   = (quot > {32'h0, NORM_ONE}) ? NORM_ONE : quot[16:0];
    assign value  = (cls.state != ST_VALID) ? 17'h0 : is_cont ? norm : raw[16:0];

    assign sig_d = (s_type == SIG_UNDEF) ? '{state: ST_NA, code: 26'h0, value: 17'h0} :
                   accept ? '{state: cls.state, code: cls.code, value: value} :
                   expire ? '{state: ST_NA, code: 26'h0, value: 17'h0} :
                   sig_q[g];

    autoreset_timer u_timer (
      .pclk     (pclk),
      .presetn  (presetn),
      .enable   (s_type != SIG_UNDEF),
      .restart  (accept),
      .ms_tick  (ms_tick),
      .limit_ms (cfg_q[g][7][ARST_W-1:0]),
      .expire   (expire)
    );

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        sig_q[g]   <= '{state: ST_NA, code: 26'h0, value: 17'h0};
        sig_upd[g] <= 1'b0;
      end else begin
        sig_q[g]   <= sig_d;
        sig_upd[g] <= accept;
      end
    end

    assign sig_out[g]              = sig_q[g];
    assign events[INT_ACC_LSB + g] = accept;
    assign events[INT_TMO_LSB + g] = expire && !accept;
  end

endmodule
`default_nettype wire

//--- hw/can_sig_pkg.sv
// Constants, register map and carrier types for the CAN input signal extractors.
package can_sig_pkg;

  // ----------------------------------------
  // Sizes and timing
  // ----------------------------------------
  localparam int NUM_EXT       = 2;
  localparam int CLK_PERIOD_NS = 5;
  localparam int NS_PER_MS     = 1000000;
  localparam int TICK_MS       = 1;
  localparam int TICK_CYCLES   = (TICK_MS * NS_PER_MS) / CLK_PERIOD_NS;
  localparam int ARST_W        = 14;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_PGN      = 8'h04;
  localparam logic [7:0] OFS_SADDR    = 8'h08;
  localparam logic [7:0] OFS_RES      = 8'h0C;
  localparam logic [7:0] OFS_OFFS     = 8'h10;
  localparam logic [7:0] OFS_MAX      = 8'h14;
  localparam logic [7:0] OFS_MIN      = 8'h18;
  localparam logic [7:0] OFS_ARST     = 8'h1C;
  localparam logic [7:0] INST_STRIDE  = 8'h20;
  localparam logic [7:0] OFS_VAL0     = 8'h40;
  localparam logic [7:0] OFS_STATE0   = 8'h44;
  localparam logic [7:0] OFS_VAL1     = 8'h48;
  localparam logic [7:0] OFS_STATE1   = 8'h4C;
  localparam logic [7:0] OFS_INT_STAT = 8'h50;
  localparam logic [7:0] OFS_INT_MASK = 8'h54;

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int CTRL_TYPE_LSB  = 0;
  localparam int CTRL_FILT_BIT  = 3;
  localparam int CTRL_BYTE_LSB  = 4;
  localparam int CTRL_BIT_LSB   = 8;
  localparam int STATE_CODE_LSB = 4;
  localparam int INT_ACC_LSB    = 0;
  localparam int INT_TMO_LSB    = 2;
  localparam int INT_W          = 4;

  localparam logic [31:0] CTRL_MASK = 32'h0000_0FFF;
  localparam logic [31:0] PGN_MASK  = 32'h0003_FFFF;
  localparam logic [31:0] SA_MASK   = 32'h0000_00FF;
  localparam logic [31:0] ARST_MASK = 32'h0000_3FFF;
  localparam logic [31:0] CTRL_RST  = 32'h0000_0110;
  localparam logic [31:0] PGN_RST   = 32'h0000_FF00;
  localparam logic [31:0] SA_RST    = 32'h0000_0000;
  localparam logic [31:0] RES_RST   = 32'h0001_0000;
  localparam logic [31:0] OFFS_RST  = 32'h0000_0000;
  localparam logic [31:0] MAX_RST   = 32'h0001_0000;
  localparam logic [31:0] MIN_RST   = 32'h0000_0000;
  localparam logic [31:0] ARST_RST  = 32'h0000_01F4;

  localparam logic [7:0]  SPECIAL_TOP = 8'hFB;
  localparam logic [7:0]  ERROR_TOP   = 8'hFE;
  localparam logic [7:0]  NA_TOP      = 8'hFF;
  localparam logic [16:0] NORM_ONE    = 17'h1_0000;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [2:0] {
    SIG_UNDEF = 3'h0,
    SIG_D1    = 3'h1,
    SIG_D2    = 3'h2,
    SIG_D4    = 3'h3,
    SIG_C1    = 3'h4,
    SIG_C2    = 3'h5,
    SIG_C4    = 3'h6
  } sig_type_t;

  typedef enum logic [1:0] {
    ST_VALID   = 2'h0,
    ST_SPECIAL = 2'h1,
    ST_ERROR   = 2'h2,
    ST_NA      = 2'h3
  } sig_state_t;

  typedef struct packed {
    logic [17:0] pgn;
    logic [7:0]  sa;
    logic        single;
    logic [63:0] data;
  } frame_t;

  typedef struct packed {
    sig_state_t  state;
    logic [25:0] code;
    logic [16:0] value;
  } sig_t;

endpackage

//--- tb/can_ext_asserts.sv
// Port assertions for the CAN input signal extractor.
`timescale 1ns/1ps
`default_nettype none
module can_ext_asserts
  import can_sig_pkg::*;
(
  input wire logic               pclk,
  input wire logic               presetn,
  input wire logic               rx_valid,
  input wire logic               lb_valid,
  input wire logic               lb_ready,
  input wire sig_t [NUM_EXT-1:0] sig_out,
  input wire logic [NUM_EXT-1:0] sig_upd
);
  // ----------------------------------------
  // Frame and output relations
  // ----------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_quiet;
    !rx_valid && !lb_valid && lb_ready;
  endsequence
  sequence s_pend;
    !lb_ready && !rx_valid;
  endsequence
  upd_cause_a: assert property (s_quiet |=> sig_upd == 2'h0)
    else $error("Output update without a frame");
  pend_drain_a: assert property (s_pend |=> lb_ready)
    else $error("Held loopback frame not drained");
  lb_store_a: assert property (rx_valid && lb_valid && lb_ready |=> !lb_ready)
    else $error("Colliding loopback frame not held");
  pend_hold_a: assert property (!lb_ready |-> $past(lb_valid && rx_valid) || $past(!lb_ready))
    else $error("Loopback stall without cause");
  val0_zero_a: assert property (sig_out[0].state != ST_VALID |-> sig_out[0].value == 17'h0)
    else $error("Value not zero on invalid state");
  val1_zero_a: assert property (sig_out[1].state != ST_VALID |-> sig_out[1].value == 17'h0)
    else $error("Value not zero on invalid state");
  code_clr_a: assert property (sig_out[0].state inside {ST_VALID, ST_NA} |-> sig_out[0].code == 0)
    else $error("Code not zero on valid or absent state");
  norm_max_a: assert property (sig_out[0].value <= NORM_ONE && sig_out[1].value <= NORM_ONE)
    else $error("Normalized value above one");
  rst_na_a: assert property (!$past(presetn) |-> sig_out[0].state == ST_NA && sig_out[1].state == ST_NA)
    else $error("Output not absent after reset");
endmodule
bind can_input_extractor can_ext_asserts u_chk (
  .pclk(pclk), .presetn(presetn), .rx_valid(rx_valid), .lb_valid(lb_valid),
  .lb_ready(lb_ready), .sig_out(sig_out), .sig_upd(sig_upd));
`default_nettype wire

//--- tb/can_node_model.sv
// Model of the other bus nodes and of the local transmit loopback.
`timescale 1ns/1ps
`default_nettype none
module can_node_model
  import can_sig_pkg::*;
(
  input  wire logic pclk,
  output logic      rx_valid,
  output frame_t    rx_frame,
  output logic      lb_valid,
  output frame_t    lb_frame,
  input  wire logic lb_ready
);
  initial begin
    rx_valid = 1'b0;
    rx_frame = '0;
    lb_valid = 1'b0;
    lb_frame = '0;
  end
  // One received frame; the bus content is scrambled once it is gone.
  task automatic send(input frame_t f);
    @(posedge pclk);
    rx_valid <= 1'b1;
    rx_frame <= f;
    @(posedge pclk);
    rx_valid <= 1'b0;
    rx_frame <= ~f;
  endtask
  // Own transmitted frame, held until taken.
  task automatic loop(input frame_t f);
    @(posedge pclk);
    lb_valid <= 1'b1;
    lb_frame <= f;
    @(posedge pclk);
    while (lb_ready !== 1'b1) @(posedge pclk);
    lb_valid <= 1'b0;
    lb_frame <= ~f;
  endtask
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// Self-checking bench for the CAN input signal extractors.
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import can_sig_pkg::*;
;
  typedef struct {
    sig_type_t   ty;
    int          byp;
    int          bip;
    logic        filt;
    logic [7:0]  sa;
    logic [31:0] res, off, mx, mn;
  } cfg_t;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        rx_valid, lb_valid, lb_ready, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  frame_t      rx_frame, lb_frame;
  sig_t [1:0]  sig_out;
  logic [1:0]  sig_upd;
  cfg_t        cf [2];
  sig_t        exq [2][$];
  logic [32:0] rq [$];
  int          errors, compares;
  logic [7:0]  ra [8] = '{OFS_CTRL, OFS_PGN, OFS_RES, OFS_MAX, OFS_ARST, OFS_STATE0,
                          OFS_INT_MASK, 8'h58};
  logic [32:0] re [8] = '{{1'b0, CTRL_RST}, {1'b0, PGN_RST}, {1'b0, RES_RST}, {1'b0, MAX_RST},
                          {1'b0, ARST_RST}, 33'h3, 33'h0, 33'h1_0000_0000};
  logic [35:0] ctab [16] = '{36'h400000000, 36'h400000001, 36'h4000000FA, 36'h4000000FB,
    36'h4000000FD, 36'h4000000FE, 36'h4000000FF, 36'h50000FAFF, 36'h50000FB05, 36'h50000FDFF,
    36'h50000FE07, 36'h50000FF12, 36'h600000100, 36'h6FB000003, 36'h6FE000005, 36'h6FF000000};
  always #2.5 pclk = ~pclk;
  can_input_extractor #(.CYCLES_PER_MS(10)) u_dut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_valid(rx_valid), .rx_frame(rx_frame), .lb_valid(lb_valid),
    .lb_frame(lb_frame), .lb_ready(lb_ready), .sig_out(sig_out), .sig_upd(sig_upd), .irq(irq));
  can_node_model u_node (
    .pclk(pclk), .rx_valid(rx_valid), .rx_frame(rx_frame), .lb_valid(lb_valid),
    .lb_frame(lb_frame), .lb_ready(lb_ready));
  // ----------------------------------------
  // Checking and bus tasks
  // ----------------------------------------
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    compares++;
    if (g !== e) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic give_verdict();
    if (errors == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd,
                     input logic [32:0] ex);
    rq.push_back(ex);
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic sig_t expect_sig(int i, logic [63:0] d);
    sig_t s;
    logic [31:0] r;
    logic [7:0] t;
    int n;
    longint sc, hi, lo;
    s = '{ST_VALID, 26'h0, 17'h0};
    r = 32'(d >> (8 * (cf[i].byp - 1)));
    if (cf[i].ty inside {SIG_D1, SIG_D2, SIG_D4}) begin
      r = (r >> (cf[i].bip - 1)) & ((cf[i].ty == SIG_D1) ? 1 : (cf[i].ty == SIG_D2) ? 3 : 15);
      if (r < 2 || cf[i].ty == SIG_D1) s.value = 17'(r);
      else if ((r == 3 && cf[i].ty == SIG_D2) || r == 15) s.state = ST_NA;
      else if (cf[i].ty == SIG_D2 || r == 14) s.state = ST_ERROR;
      else s = '{ST_SPECIAL, 26'(r - 2), 17'h0};
      return s;
    end
    n = (cf[i].ty == SIG_C1) ? 8 : (cf[i].ty == SIG_C2) ? 16 : 32;
    if (n < 32) r = r & ((32'h1 << n) - 1);
    t = 8'(r >> (n - 8));
    if (t == NA_TOP) s.state = ST_NA;
    else if (t >= SPECIAL_TOP) begin
      s.state = (t == ERROR_TOP) ? ST_ERROR : ST_SPECIAL;
      s.code = 26'(r - (32'((t == ERROR_TOP) ? ERROR_TOP : SPECIAL_TOP) << (n - 8)));
    end else begin
      hi = $signed(cf[i].mx);
      lo = $signed(cf[i].mn);
      sc = longint'(r) * $signed(cf[i].res) + $signed(cf[i].off);
      if (sc > hi) sc = hi;
      if (sc < lo) sc = lo;
      sc = ((sc - lo) << 16) / (hi - lo);
      s.value = 17'(sc);
    end
    return s;
  endfunction
  task automatic note(input frame_t f);
    for (int i = 0; i < NUM_EXT; i++) begin
      if (f.single && f.pgn == PGN_RST[17:0] && cf[i].ty != SIG_UNDEF
          && (!cf[i].filt || f.sa == cf[i].sa)) exq[i].push_back(expect_sig(i, f.data));
    end
  endtask
  task automatic send(input frame_t f, input logic lb = 1'b0);
    note(f);
    if (lb) u_node.loop(f);
    else u_node.send(f);
  endtask
  function automatic frame_t mkf(logic [7:0] sa, logic [63:0] d);
    return '{PGN_RST[17:0], sa, 1'b1, d};
  endfunction
  task automatic put(input int i, input logic [31:0] c, input int n);
    logic [63:0] d, m;
    int sh;
    sh = 8 * (cf[i].byp - 1) + ((n < 8) ? cf[i].bip - 1 : 0);
    m = (64'h1 << n) - 1;
    d = {$urandom, $urandom};
    send(mkf(8'hFD, (d & ~(m << sh)) | ((64'(c) & m) << sh)));
  endtask
  task automatic set_cfg(input int i);
    logic [7:0] b;
    b = 8'(i) * INST_STRIDE;
    apb(b + OFS_CTRL, 1, {20'h0, 4'(cf[i].bip), 4'(cf[i].byp), cf[i].filt, cf[i].ty}, 33'h0);
    apb(b + OFS_SADDR, 1, {24'h0, cf[i].sa}, 33'h0);
    apb(b + OFS_RES, 1, cf[i].res, 33'h0);
    apb(b + OFS_OFFS, 1, cf[i].off, 33'h0);
    apb(b + OFS_MAX, 1, cf[i].mx, 33'h0);
    apb(b + OFS_MIN, 1, cf[i].mn, 33'h0);
  endtask
  // ----------------------------------------
  // Output monitor, watchdog and tests
  // ----------------------------------------
  always @(posedge pclk) begin : mon
    logic [63:0] e;
    if (psel && penable && pready === 1'b1) begin
      e = '1;
      if (rq.size() > 0) e = 64'(rq.pop_front());
      chk({pslverr, prdata}, e);
    end
    for (int i = 0; i < NUM_EXT; i++) begin
      if (sig_upd[i] === 1'b1) begin
        e = '1;
        if (exq[i].size() > 0) e = 64'(exq[i].pop_front());
        chk(sig_out[i], e);
      end
    end
  end
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    give_verdict();
  end
  initial begin
    sig_type_t ty;
    logic [31:0] c;
    frame_t f, g;
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    errors = 0;
    compares = 0;
    for (int i = 0; i < 2; i++) cf[i] = '{SIG_UNDEF, 1, 1, 1'b0, 8'h0, RES_RST, 0, MAX_RST, 0};
    void'($urandom(62));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    for (int k = 0; k < 8; k++) apb(ra[k], 0, 0, re[k]);
    apb(OFS_VAL0, 1, 32'h1, 33'h1_0000_0000);
    put(0, 32'h3, 8);
    for (int t = 1; t < 4; t++) begin
      cf[0] = '{sig_type_t'(t), 3, 5, 1'b0, 8'h0, RES_RST, 0, MAX_RST, 0};
      set_cfg(0);
      for (int k = 0; k < 16; k++) put(0, k, 4);
    end
    cf[1].mx = 32'h0100_0000;
    for (int k = 0; k < 16; k++) begin
      ty = sig_type_t'(ctab[k][34:32]);
      c = (k == 1) ? $urandom_range(239) : ctab[k][31:0];
      if (ty != cf[1].ty) begin
        cf[1].ty = ty;
        cf[1].byp = (ty == SIG_C1) ? 2 : (ty == SIG_C2) ? 7 : 5;
        cf[1].res = (ty == SIG_C1) ? RES_RST : 32'h100;
        cf[1].off = (ty == SIG_C1) ? 32'h10_0000 : 0;
        set_cfg(1);
      end
      put(1, c, (ty == SIG_C1) ? 8 : (ty == SIG_C2) ? 16 : 32);
    end
    cf[1].filt = 1'b1;
    cf[1].sa = 8'hFD;
    set_cfg(1);
    put(1, 32'h100, 32);
    send(mkf(8'h07, {$urandom, $urandom}));
    f = mkf(8'hFD, {$urandom, $urandom});
    f.pgn = 18'h0FF01;
    send(f);
    f = mkf(8'hFD, {$urandom, $urandom});
    f.single = 1'b0;
    send(f);
    send(mkf(8'hFD, {$urandom, $urandom}), 1'b1);
    f = mkf(8'hFD, {$urandom, $urandom});
    g = mkf(8'hFD, 64'h0000_0200_FE00_0000);
    note(f);
    note(g);
    fork
      u_node.send(f);
      u_node.loop(g);
    join
    apb(OFS_INT_STAT, 1, 32'hF, 33'h0);
    apb(OFS_ARST, 1, 32'h3, 33'h0);
    apb(INST_STRIDE + OFS_ARST, 1, 32'h0, 33'h0);
    send(mkf(8'hFD, 64'h0));
    repeat (15) @(negedge pclk);
    chk(sig_out[0].state, ST_VALID);
    repeat (40) @(negedge pclk);
    chk(sig_out[0], sig_t'{ST_NA, 26'h0, 17'h0});
    chk(sig_out[1].state, ST_VALID);
    apb(OFS_INT_STAT, 0, 0, 33'h7);
    chk(irq, 1'b0);
    apb(OFS_INT_MASK, 1, 32'h4, 33'h0);
    #1 chk(irq, 1'b1);
    apb(OFS_INT_STAT, 1, 32'h4, 33'h0);
    #1 chk(irq, 1'b0);
    repeat (4) @(negedge pclk);
    chk(exq[0].size() + exq[1].size() + rq.size(), 0);
    give_verdict();
  end
endmodule
`default_nettype wire
